// >>> core/link_shifter.sv
`timescale 1ns/10ps
`include "pmr_defs.svh"
module link_shifter (
  // core reset, clears the event toggle
  input wire logic rst_i,
  // link clock and frame
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic octal_i,
  // data lines
  input wire logic [7:0] dq_in_i,
  output logic [7:0] dq_out_o,
  output logic [7:0] dq_oe_o,
  // register value, stable between writes
  input wire logic [7:0] prot_value_i,
  // captured write
  output pmr_pkg::write_req_s req_o,
  output logic req_toggle_o
);
  pmr_pkg::link_state_e state;
  logic [7:0] shift;
  logic [3:0] count;
  logic byte_done;
  logic [7:0] next_shift;

  always_comb begin
    next_shift = octal_i ? dq_in_i : {shift[6:0], dq_in_i[0]};
  end

  always_comb begin
    byte_done = octal_i || (count == 4'h7);
  end

  // frame held in reset while deselected; link clock may stop
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      state <= pmr_pkg::LINK_CMD;
      count <= 4'h0;
      shift <= 8'h00;
    end else begin
      shift <= next_shift;
      count <= byte_done ? 4'h0 : count + 4'h1;
      unique case (state)
        pmr_pkg::LINK_CMD: begin
          if (byte_done) begin
            if (next_shift == `CMD_READ_PROT) begin
              state <= octal_i ? pmr_pkg::LINK_DUMMY : pmr_pkg::LINK_READ;
            end else if (next_shift == `CMD_WRITE_PROT) begin
              state <= pmr_pkg::LINK_DATA;
            end else begin
              state <= pmr_pkg::LINK_IGNORE;
            end
          end
        end
        pmr_pkg::LINK_DUMMY: begin
          if (count == 4'(`OCTAL_DUMMY_CYCLES - 1)) begin
            state <= pmr_pkg::LINK_READ;
            count <= 4'h0;
          end else begin
            count <= count + 4'h1;
          end
        end
        pmr_pkg::LINK_READ: begin
          count <= 4'h0;
        end
        pmr_pkg::LINK_DATA: begin
          if (byte_done) begin
            state <= pmr_pkg::LINK_DONE;
          end
        end
        pmr_pkg::LINK_DONE: begin
          state <= pmr_pkg::LINK_IGNORE;
        end
        pmr_pkg::LINK_IGNORE: begin
          count <= 4'h0;
        end
      endcase
    end
  end

  // output changes on falling edge, same byte repeats
  logic [2:0] bit_idx;
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      dq_out_o <= 8'h00;
      dq_oe_o <= 8'h00;
      bit_idx <= 3'h7;
    end else if (state == pmr_pkg::LINK_READ) begin
      if (octal_i) begin
        dq_out_o <= prot_value_i;
        dq_oe_o <= 8'hFF;
      end else begin
        dq_out_o <= {6'h00, prot_value_i[bit_idx], 1'b0};
        dq_oe_o <= 8'h02;
        bit_idx <= bit_idx - 3'h1;
      end
    end
  end

  // write armed only while last data byte is complete at cs rise
  // data only moves with the toggle, so the core never sees it change mid-use
  always_ff @(posedge cs_n_i or posedge rst_i) begin
    if (rst_i) begin
      req_o <= '{wel: 1'b0, data: 8'hFF};
      req_toggle_o <= 1'b0;
    end else if (state == pmr_pkg::LINK_DONE) begin
      req_o <= '{wel: 1'b1, data: shift};
      req_toggle_o <= ~req_toggle_o;
    end
  end
endmodule

// >>> core/prot_mgmt_core.sv
`timescale 1ns/10ps
`include "pmr_defs.svh"
// Functional notes
// - read command returns register contents
// - write programs any subset of bits zero, one, two, four
// - programmed bits never return to one; here rst_i reloads 8'hFF
// - read lines: single in/out or octal both
// - chip select high stops output immediately
// - no dummies extended, eight dummies octal
// - continued read repeats the same byte
// - misframed write discarded, flags unchanged
// - write data on one or eight lines
// - self-timed programming for protection_write_time
// - busy high during programming, cleared after
// - executed write clears write enable latch
// - status readable, controller flag returns high
// - reserved zero aborts, sets both errors
// - lockdown zero refuses, keeps enable latch
// - rejection reported in flag bits one, four
// - bit two is permanent lockdown
// - bit four blocks status register writes
module prot_mgmt_core #(
  parameter int unsigned WRITE_CYCLES = `PROT_WRITE_CYCLES
) (
  // core clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic octal_i,
  input wire logic [7:0] dq_in_i,
  output logic [7:0] dq_out_o,
  output logic [7:0] dq_oe_o,
  // write enable latch control from the command decoder
  input wire logic wel_set_i,
  // status
  output logic busy_o,
  output logic wel_o,
  output logic ctrl_ready_o,
  output logic prog_err_o,
  output logic prot_err_o,
  output logic sr_write_lock_o,
  output logic [7:0] prot_value_o
);
  initial begin
    if (WRITE_CYCLES < 1) $error("write time below one cycle");
  end

  // ------------------------------------------------------------
  // link side
  // ------------------------------------------------------------
  pmr_pkg::write_req_s req;
  logic req_toggle;
  logic [7:0] prot_value;

  link_shifter u_link (
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .octal_i(octal_i),
    .dq_in_i(dq_in_i),
    .dq_out_o(dq_out_o),
    .dq_oe_o(dq_oe_o),
    .prot_value_i(prot_value),
    .req_o(req),
    .req_toggle_o(req_toggle)
  );

  // ------------------------------------------------------------
  // crossing: toggle event, data stable while toggle settles
  // ------------------------------------------------------------
  logic toggle_sync;
  logic toggle_seen;
  logic req_pulse;

  sync_bit u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(req_toggle),
    .q_o(toggle_sync)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      toggle_seen <= 1'b0;
    end else begin
      toggle_seen <= toggle_sync;
    end
  end
  assign req_pulse = toggle_sync ^ toggle_seen;

  // ------------------------------------------------------------
  // programming sequencer
  // ------------------------------------------------------------
  pmr_pkg::prog_state_e state;
  logic [31:0] timer;
  logic [7:0] pending;
  logic abort;
  logic locked;

  // data sampled three edges after the toggle, long settled
  assign locked = ~prot_value[`PROT_LOCKDOWN_BIT];
  assign abort = (req.data & `PROT_RESERVED_MASK) != `PROT_RESERVED_MASK;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= pmr_pkg::PROG_IDLE;
      timer <= 32'h0;
      pending <= 8'hFF;
    end else begin
      unique case (state)
        pmr_pkg::PROG_IDLE: begin
          if (req_pulse && wel_o && !locked) begin
            state <= pmr_pkg::PROG_BUSY;
            timer <= 32'(WRITE_CYCLES - 1);
            pending <= abort ? 8'hFF : req.data;
          end
        end
        pmr_pkg::PROG_BUSY: begin
          if (timer == 32'h0) begin
            state <= pmr_pkg::PROG_IDLE;
          end else begin
            timer <= timer - 32'h1;
          end
        end
      endcase
    end
  end

  // otp array: only ones may fall to zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prot_value <= `PROT_RESET_VALUE;
    end else if (state == pmr_pkg::PROG_BUSY && timer == 32'h0) begin
      prot_value <= prot_value & pending;
    end
  end

  // write enable latch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wel_o <= 1'b0;
    end else if (req_pulse && wel_o && !locked) begin
      wel_o <= 1'b0;
    end else if (wel_set_i) begin
      wel_o <= 1'b1;
    end
  end

  // error flags, sticky until device reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_err_o <= 1'b0;
      prot_err_o <= 1'b0;
    end else if (req_pulse && wel_o) begin
      if (locked) begin
        prog_err_o <= 1'b1;
        prot_err_o <= 1'b1;
      end else if (abort) begin
        prog_err_o <= 1'b1;
        prot_err_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      ctrl_ready_o <= 1'b1;
      sr_write_lock_o <= 1'b0;
      prot_value_o <= `PROT_RESET_VALUE;
    end else begin
      busy_o <= (state == pmr_pkg::PROG_BUSY) && (timer != 32'h0);
      ctrl_ready_o <= !((state == pmr_pkg::PROG_BUSY) && (timer != 32'h0));
      sr_write_lock_o <= ~prot_value[`PROT_SR_LOCK_BIT];
      prot_value_o <= prot_value;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_otp_monotonic;
    @(posedge clk_i) disable iff (rst_i)
      (prot_value & ~$past(prot_value)) == 8'h00;
  endproperty
  a_otp_monotonic: assert property (p_otp_monotonic) else $error("otp bit returned");

  property p_lock_keeps_wel;
    @(posedge clk_i) disable iff (rst_i)
      (req_pulse && wel_o && locked && !wel_set_i) |=> wel_o && prot_err_o && prog_err_o;
  endproperty
  a_lock_keeps_wel: assert property (p_lock_keeps_wel) else $error("locked write mishandled");

  property p_start_busy;
    @(posedge clk_i) disable iff (rst_i)
      (state == pmr_pkg::PROG_IDLE && req_pulse && wel_o && !locked && WRITE_CYCLES > 1)
        |=> ##1 busy_o && !ctrl_ready_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not raised");

  property p_exec_clears_wel;
    @(posedge clk_i) disable iff (rst_i)
      (req_pulse && wel_o && !locked && !wel_set_i) |=> !wel_o;
  endproperty
  a_exec_clears_wel: assert property (p_exec_clears_wel) else $error("wel not cleared");

  property p_abort_errors;
    @(posedge clk_i) disable iff (rst_i)
      (req_pulse && wel_o && !locked && abort) |=> prog_err_o && prot_err_o;
  endproperty
  a_abort_errors: assert property (p_abort_errors) else $error("abort flags missing");

  property p_no_req_no_change;
    @(posedge clk_i) disable iff (rst_i)
      (state == pmr_pkg::PROG_IDLE) |=> prot_value == $past(prot_value);
  endproperty
  a_no_req_no_change: assert property (p_no_req_no_change) else $error("value changed idle");

  property p_ready_inverse;
    @(posedge clk_i) disable iff (rst_i) ctrl_ready_o == !busy_o;
  endproperty
  a_ready_inverse: assert property (p_ready_inverse) else $error("flags disagree");

  property p_sr_lock;
    @(posedge clk_i) disable iff (rst_i)
      ##1 sr_write_lock_o == !$past(prot_value[`PROT_SR_LOCK_BIT]);
  endproperty
  a_sr_lock: assert property (p_sr_lock) else $error("sr lock wrong");

  property p_lock_no_start;
    @(posedge clk_i) disable iff (rst_i)
      (state == pmr_pkg::PROG_IDLE && req_pulse && locked) |=> state == pmr_pkg::PROG_IDLE;
  endproperty
  a_lock_no_start: assert property (p_lock_no_start) else $error("locked write started");

  property p_abort_keeps_value;
    @(posedge clk_i) disable iff (rst_i)
      (state == pmr_pkg::PROG_BUSY && pending == 8'hFF) |=> prot_value == $past(prot_value);
  endproperty
  a_abort_keeps_value: assert property (p_abort_keeps_value) else $error("abort programmed");

  property p_busy_ends;
    @(posedge clk_i) disable iff (rst_i)
      (state == pmr_pkg::PROG_BUSY && timer == 32'h0) |=> state == pmr_pkg::PROG_IDLE && !busy_o;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("busy not cleared");

  property p_wel_set;
    @(posedge clk_i) disable iff (rst_i)
      (wel_set_i && !req_pulse) |=> wel_o;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");

  // no clear command exists, so a raised error must stay up
  property p_err_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (prog_err_o && prot_err_o) |=> prog_err_o && prot_err_o;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

  property p_idle_ready;
    @(posedge clk_i) disable iff (rst_i)
      (state == pmr_pkg::PROG_IDLE) |=> ctrl_ready_o;
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("ready low while idle");
endmodule

// >>> core/sync_bit.sv
`timescale 1ns/10ps
module sync_bit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;

  // first stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// >>> shared/pmr_defs.svh
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH
`define CMD_READ_PROT 8'h2B
`define CMD_WRITE_PROT 8'h68
`define PROT_LOCKDOWN_BIT 2
`define PROT_SR_LOCK_BIT 4
`define PROT_RESERVED_MASK 8'hE8
`define PROT_RESET_VALUE 8'hFF
`define OCTAL_DUMMY_CYCLES 8
`define FSR_PROT_ERR_BIT 1
`define FSR_PROG_ERR_BIT 4
`define CLK_PERIOD_PS 5000
`define PROT_WRITE_TIME_NS 200000
`define PROT_WRITE_CYCLES ((`PROT_WRITE_TIME_NS * 1000) / `CLK_PERIOD_PS)
`endif

// >>> shared/pmr_pkg.sv
package pmr_pkg;
  // one captured write command handed to the core clock
  typedef struct packed {
    logic wel;
    logic [7:0] data;
  } write_req_s;
  typedef enum logic [2:0] {
    LINK_CMD,
    LINK_DUMMY,
    LINK_READ,
    LINK_DATA,
    LINK_DONE,
    LINK_IGNORE
  } link_state_e;
  typedef enum logic [1:0] {
    PROG_IDLE,
    PROG_BUSY
  } prog_state_e;
endpackage

// >>> test/host_model.sv
`timescale 1ns/10ps
module host_model (
  // link outputs
  output logic sclk_o,
  output logic cs_n_o,
  output logic [7:0] dq_o,
  // lines seen by the host
  input wire logic [7:0] dq_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 8'h00;
  end
  // link clock stands still between frames
  task automatic tick();
    #3 sclk_o = 1'b1;
    #3 sclk_o = 1'b0;
  endtask
  task automatic start();
    cs_n_o = 1'b0;
    #2;
  endtask
  // select rises only after the last bit
  task automatic stop();
    #2;
    cs_n_o = 1'b1;
    dq_o = ~dq_o;
    #10;
  endtask
  // unused lines toggle so nothing looks stable
  task automatic send(input logic [7:0] b, input logic oct);
    if (oct) begin
      dq_o = b;
      tick();
    end else begin
      for (int i = 7; i >= 0; i--) begin
        dq_o = {~dq_o[7:1], b[i]};
        tick();
      end
    end
  endtask
  task automatic recv(input logic oct, output logic [7:0] b);
    b = 8'h00;
    dq_o = ~dq_o;
    for (int i = 7; i >= 0; i--) begin
      #3;
      if (oct) b = dq_i;
      else b[i] = dq_i[1];
      sclk_o = 1'b1;
      #3;
      sclk_o = 1'b0;
      if (oct) break;
    end
  endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/10ps
`include "pmr_defs.svh"
module testbench;
  localparam int unsigned WCYC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic octal_i = 1'b0;
  logic wel_set_i = 1'b0;
  logic sclk, cs_n, busy, wel, ready, perr, terr, srlock;
  logic [7:0] host_dq, dq_in, dq_out, dq_oe, value, flags;
  int mismatches = 0;
  int n_compared = 0;
  int busy_cnt = 0;
  int busy_len = 0;
  always #2.5 clk_i = ~clk_i;
  // wire level from the device's enables, host drives the rest
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & host_dq);
  assign flags = {2'h0, busy, wel, ready, perr, terr, srlock};
  host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .dq_o(host_dq), .dq_i(dq_in));
  prot_mgmt_core #(.WRITE_CYCLES(WCYC)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .octal_i(octal_i), .dq_in_i(dq_in),
    .dq_out_o(dq_out), .dq_oe_o(dq_oe), .wel_set_i(wel_set_i), .busy_o(busy),
    .wel_o(wel), .ctrl_ready_o(ready), .prog_err_o(perr), .prot_err_o(terr),
    .sr_write_lock_o(srlock), .prot_value_o(value));
  always @(posedge clk_i) begin
    if (busy === 1'b1) busy_cnt++;
    else if (busy_cnt != 0) begin
      busy_len = busy_cnt;
      busy_cnt = 0;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic enable_write();
    @(posedge clk_i);
    wel_set_i <= 1'b1;
    @(posedge clk_i);
    wel_set_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic frame(input logic oct, input logic [7:0] cmd);
    @(posedge clk_i);
    octal_i <= oct;
    @(posedge clk_i);
    i_host.start();
    i_host.send(cmd, oct);
  endtask
  // extra adds one sclk pulse after the data byte
  task automatic write_reg(input logic oct, input logic [7:0] d, input logic extra);
    frame(oct, `CMD_WRITE_PROT);
    i_host.send(d, oct);
    if (extra) i_host.tick();
    i_host.stop();
  endtask
  task automatic wait_prog(input logic look, input logic exp);
    int n;
    n = 0;
    busy_len = 0;
    repeat (4) @(posedge clk_i);
    if (look) check({7'h00, busy}, {7'h00, exp});
    while (ready !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check({7'h00, ready}, 8'h01);
    repeat (2) @(posedge clk_i);
    if (look && exp) check(8'(busy_len), 8'(WCYC - 1));
  endtask
  task automatic read_reg(input logic oct, input logic [7:0] exp);
    logic [7:0] b;
    frame(oct, `CMD_READ_PROT);
    if (oct) repeat (`OCTAL_DUMMY_CYCLES) i_host.tick();
    repeat (3) begin
      i_host.recv(oct, b);
      check(b, exp);
    end
    check(dq_oe, oct ? 8'hFF : 8'h02);
    i_host.stop();
    check(dq_oe, 8'h00);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(flags, 8'h08);
    check(value, 8'hFF);
  endtask
  initial begin
    #30000;
    mismatches++;
    finish_test();
  end
  initial begin
    do_reset();
    check(dq_oe, 8'h00);
    read_reg(1'b0, 8'hFF);
    // write without the latch set is not executed
    write_reg(1'b0, 8'hFE, 1'b0);
    wait_prog(1'b1, 1'b0);
    check(value, 8'hFF);
    enable_write();
    check(flags, 8'h18);
    write_reg(1'b0, 8'hFE, 1'b1);
    wait_prog(1'b1, 1'b0);
    check(flags, 8'h18);
    check(value, 8'hFF);
    write_reg(1'b0, 8'hFE, 1'b0);
    wait_prog(1'b1, 1'b1);
    check(flags, 8'h08);
    check(value, 8'hFE);
    enable_write();
    write_reg(1'b1, 8'hEF, 1'b0);
    wait_prog(1'b1, 1'b1);
    check(value, 8'hEE);
    check(flags, 8'h09);
    read_reg(1'b1, 8'hEE);
    read_reg(1'b0, 8'hEE);
    enable_write();
    write_reg(1'b0, 8'hFF, 1'b0);
    wait_prog(1'b1, 1'b1);
    check(value, 8'hEE);
    enable_write();
    write_reg(1'b0, 8'h6F, 1'b0);
    wait_prog(1'b1, 1'b1);
    check(value, 8'hEE);
    check(flags, 8'h0F);
    // errors are sticky, so reset before the lockdown case
    do_reset();
    enable_write();
    write_reg(1'b1, 8'hFB, 1'b0);
    wait_prog(1'b1, 1'b1);
    check(value, 8'hFB);
    enable_write();
    write_reg(1'b0, 8'hFA, 1'b0);
    wait_prog(1'b0, 1'b0);
    check(value, 8'hFB);
    check(flags, 8'h1E);
    finish_test();
  end
endmodule
